// ### usir_pkg.sv
// Shared constants and carrier types for the serial port status and event block
package usir_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned LVL_W = 4;
	localparam int unsigned EV_W = 7;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_PORT_CONTROL = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_PORT_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_EVENT_ENABLE = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_EVENT_FLAGS = 12'h00C;

	// port_control fields
	localparam int unsigned CTRL_THRESH_LSB = 0;
	localparam logic [LVL_W-1:0] CTRL_THRESH_RST = 4'h0;
	localparam logic [LVL_W-1:0] THRESH_MIN = 4'h1;

	// port_status fields
	localparam int unsigned STAT_TX_LVL_LSB = 12;
	localparam int unsigned STAT_RX_LVL_LSB = 8;
	localparam int unsigned STAT_TX_FULL = 7;
	localparam int unsigned STAT_TX_EMPTY = 6;
	localparam int unsigned STAT_RX_FULL = 5;
	localparam int unsigned STAT_RX_EMPTY = 4;
	localparam int unsigned STAT_RX_BUSY = 1;
	localparam int unsigned STAT_TX_BUSY = 0;

	// Event bit positions, shared by event_enable and event_flags
	localparam int unsigned EV_TX_HALF = 6;
	localparam int unsigned EV_TX_NEAR = 5;
	localparam int unsigned EV_RX_THRESH = 4;
	localparam int unsigned EV_RX_OVERRUN = 3;
	localparam int unsigned EV_CTS_CHANGE = 2;
	localparam int unsigned EV_RX_PARITY = 1;
	localparam int unsigned EV_RX_FRAME = 0;
	localparam logic [EV_W-1:0] EV_ENABLE_RST = 7'h00;
	localparam logic [EV_W-1:0] EV_FLAGS_RST = 7'h00;

	// Queue geometry
	localparam int unsigned QUEUE_DEPTH = 8;
	localparam logic [LVL_W-1:0] LEVEL_RST = 4'h0;
	localparam logic [LVL_W-1:0] TX_NEAR_LVL = 4'h1;

	// Synchroniser fill time before the clear-to-send compare is trusted
	localparam int unsigned CTS_PRIME_CYC = 3;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} usir_apb_req_type;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} usir_apb_rsp_type;

endpackage

// ### usir_queue_level.sv
// Occupancy tracker for one character queue: level, full, empty and overflow
`timescale 1ns/1ps
module usir_queue_level import usir_pkg::*; #(
	parameter int unsigned DEPTH = QUEUE_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_push,
	input wire logic i_pop,
	output logic [LVL_W-1:0] o_level,
	output logic o_full,
	output logic o_empty,
	output logic o_overflow
);

	localparam logic [LVL_W-1:0] DEPTH_L = LVL_W'(DEPTH);

	logic [LVL_W-1:0] level_r;
	logic [LVL_W-1:0] level_nxt;
	logic overflow_r;
	logic full_now;
	logic empty_now;

	assign full_now = (level_r == DEPTH_L);
	assign empty_now = (level_r == LEVEL_RST);

	// Saturate at DEPTH; a push into a full queue with no pop is lost
	always_comb begin
		level_nxt = level_r;
		if (i_push && !i_pop && !full_now) begin
			level_nxt = level_r + 4'h1;
		end else if (i_pop && !i_push && !empty_now) begin
			level_nxt = level_r - 4'h1;
		end else if (i_pop && i_push && empty_now) begin
			level_nxt = level_r + 4'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			level_r <= LEVEL_RST;
		end else begin
			level_r <= level_nxt;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			overflow_r <= 1'b0;
		end else begin
			overflow_r <= i_push && !i_pop && full_now;
		end
	end

	assign o_level = level_r;
	assign o_full = full_now;
	assign o_empty = empty_now;
	assign o_overflow = overflow_r;

endmodule

// ### uart_status_irq_regs.sv
// APB register block for serial port queue status, event flags and interrupt
//
// How it works
// - Control bits 3:0 hold the receive threshold; software keeps it within 1 to 8.
// - Status bits 15:12 show transmit queue occupancy, 0 to 8.
// - Status bits 11:8 show receive queue occupancy, 0 to 8.
// - Status bit 1 is high while a character is being received; resets low.
// - Status bit 0 is high while data shifts out; resets low.
// - Enable bit 6 lets the transmit half-empty event raise the interrupt.
// - Flag bit 6 latches transmit half-empty; write 1 clears, 0 does nothing.
// - Enable bit 5 lets the transmit almost-empty event raise the interrupt.
// - Flag bit 5 latches transmit almost-empty; cleared by writing 1.
// - Enable bit 4 lets the receive threshold event raise the interrupt.
// - Flag bit 4 latches the receive threshold event; cleared by writing 1.
// - Enable bit 3 lets a receive overrun raise the interrupt.
// - Flag bit 3 latches a receive overrun until software writes 1.
// - Enable bit 2 lets a clear-to-send change raise the interrupt.
// - Flag bit 2 latches a clear-to-send change once the synchroniser has filled after reset; cleared by writing 1.
// - Enable bit 1 lets a receive parity error raise the interrupt.
// - Flag bit 1 latches a receive parity error until software writes 1.
// - Enable bit 0 lets a receive framing error raise the interrupt.
// - Flag bit 0 latches a receive framing error; cleared by writing 1.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module uart_status_irq_regs import usir_pkg::*; #(
	parameter int unsigned receive_queue_depth_param = QUEUE_DEPTH,
	parameter int unsigned TX_QUEUE_DEPTH = QUEUE_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire usir_apb_req_type i_apb,
	output usir_apb_rsp_type o_apb,
	input wire logic i_tx_push,
	input wire logic i_tx_pop,
	input wire logic i_rx_push,
	input wire logic i_rx_pop,
	input wire logic i_tx_busy,
	input wire logic i_rx_busy,
	input wire logic i_rx_parity_err,
	input wire logic i_rx_frame_err,
	input wire logic i_cts,
	output logic [LVL_W-1:0] o_rx_threshold,
	output logic o_irq
);

	localparam logic [LVL_W-1:0] TX_HALF_LVL = LVL_W'(TX_QUEUE_DEPTH / 2);

	// Bus side
	usir_apb_rsp_type apb_rsp_r;
	logic [ADDR_W-1:0] addr_word;
	logic addr_ok;
	logic access_ph;
	logic wr_fire;
	logic hit_ctrl;
	logic hit_stat;
	logic hit_en;
	logic hit_fl;
	logic map_hit;
	logic ctrl_write;
	logic en_write;
	logic fl_write;
	logic [DATA_W-1:0] ctrl_word;
	logic [DATA_W-1:0] stat_word;
	logic [DATA_W-1:0] en_word;
	logic [DATA_W-1:0] fl_word;
	logic [DATA_W-1:0] rd_mux;

	// Registers
	logic [LVL_W-1:0] thresh_r;
	logic [EV_W-1:0] enable_r;
	logic [EV_W-1:0] flags_r;
	logic [EV_W-1:0] ev_set;
	logic [EV_W-1:0] ev_clr;
	logic irq_r;
	logic irq_nxt;

	// Line side status
	logic tx_busy_r;
	logic rx_busy_r;
	logic [LVL_W-1:0] tx_level;
	logic [LVL_W-1:0] rx_level;
	logic tx_full;
	logic tx_empty;
	logic rx_full;
	logic rx_empty;
	logic rx_overflow;
	logic [LVL_W-1:0] tx_level_prev_r;
	logic [LVL_W-1:0] rx_level_prev_r;

	// Clear-to-send synchroniser and change detect
	logic cts_meta_r;
	logic cts_sync_r;
	logic cts_prev_r;
	logic [CTS_PRIME_CYC-1:0] cts_prime_r;
	logic cts_change;

	// Event pulses
	logic tx_half_ev;
	logic tx_near_ev;
	logic rx_thresh_ev;

	// Levels saturate inside the trackers, so codes above the depth never appear
	usir_queue_level #(
		.DEPTH(TX_QUEUE_DEPTH)
	) u_tx_level (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_push(i_tx_push),
		.i_pop(i_tx_pop),
		.o_level(tx_level),
		.o_full(tx_full),
		.o_empty(tx_empty),
		.o_overflow()
	);

	usir_queue_level #(
		.DEPTH(receive_queue_depth_param)
	) u_rx_level (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_push(i_rx_push),
		.i_pop(i_rx_pop),
		.o_level(rx_level),
		.o_full(rx_full),
		.o_empty(rx_empty),
		.o_overflow(rx_overflow)
	);

	// Address decode: word aligned, four registers in the map
	assign addr_word = {i_apb.paddr[ADDR_W-1:2], 2'b00};
	assign addr_ok = (i_apb.paddr[1:0] == 2'b00);
	assign hit_ctrl = addr_ok && (addr_word == OFF_PORT_CONTROL);
	assign hit_stat = addr_ok && (addr_word == OFF_PORT_STATUS);
	assign hit_en = addr_ok && (addr_word == OFF_EVENT_ENABLE);
	assign hit_fl = addr_ok && (addr_word == OFF_EVENT_FLAGS);
	assign access_ph = i_apb.psel && i_apb.penable;
	assign map_hit = hit_ctrl || hit_stat || hit_en || hit_fl;

	// Writes land only on the edge where the master sees pready high
	assign wr_fire = access_ph && apb_rsp_r.pready && i_apb.pwrite;

	// Status is read only; a write to it is dropped without an error
	assign ctrl_write = wr_fire && hit_ctrl;
	assign en_write = wr_fire && hit_en;
	assign fl_write = wr_fire && hit_fl;

	// Each register word is built on its own; unused bits read 0
	always_comb begin
		ctrl_word = '0;
		ctrl_word[CTRL_THRESH_LSB +: LVL_W] = thresh_r;
	end

	always_comb begin
		stat_word = '0;
		stat_word[STAT_TX_LVL_LSB +: LVL_W] = tx_level;
		stat_word[STAT_RX_LVL_LSB +: LVL_W] = rx_level;
		stat_word[STAT_TX_FULL] = tx_full;
		stat_word[STAT_TX_EMPTY] = tx_empty;
		stat_word[STAT_RX_FULL] = rx_full;
		stat_word[STAT_RX_EMPTY] = rx_empty;
		stat_word[STAT_RX_BUSY] = rx_busy_r;
		stat_word[STAT_TX_BUSY] = tx_busy_r;
	end

	always_comb begin
		en_word = '0;
		en_word[EV_W-1:0] = enable_r;
	end

	always_comb begin
		fl_word = '0;
		fl_word[EV_W-1:0] = flags_r;
	end

	// Unmapped and unaligned addresses read 0
	always_comb begin
		rd_mux = '0;
		if (hit_ctrl) begin
			rd_mux = ctrl_word;
		end else if (hit_stat) begin
			rd_mux = stat_word;
		end else if (hit_en) begin
			rd_mux = en_word;
		end else if (hit_fl) begin
			rd_mux = fl_word;
		end
	end

	// One wait state: pready rises on the second access cycle, then drops
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			apb_rsp_r.pready <= 1'b0;
		end else begin
			apb_rsp_r.pready <= access_ph && !apb_rsp_r.pready;
		end
	end

	// The error answer stands with pready for one cycle only
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			apb_rsp_r.pslverr <= 1'b0;
		end else begin
			apb_rsp_r.pslverr <= access_ph && !apb_rsp_r.pready && !map_hit;
		end
	end

	// Read data stays until the next answer; a write answers with 0
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			apb_rsp_r.prdata <= '0;
		end else if (access_ph && !apb_rsp_r.pready) begin
			apb_rsp_r.prdata <= i_apb.pwrite ? '0 : rd_mux;
		end
	end

	// Threshold field stores what software writes; only 1 to 8 are meaningful
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			thresh_r <= CTRL_THRESH_RST;
		end else if (ctrl_write) begin
			thresh_r <= i_apb.pwdata[CTRL_THRESH_LSB +: LVL_W];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			enable_r <= EV_ENABLE_RST;
		end else if (en_write) begin
			enable_r <= i_apb.pwdata[EV_W-1:0];
		end
	end

	// Busy inputs come from the shifters on this clock; one register stage only
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_busy_r <= 1'b0;
		end else begin
			tx_busy_r <= i_tx_busy;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_busy_r <= 1'b0;
		end else begin
			rx_busy_r <= i_rx_busy;
		end
	end

	// Previous levels let the events fire only on the crossing, not while parked
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_level_prev_r <= LEVEL_RST;
		end else begin
			tx_level_prev_r <= tx_level;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_level_prev_r <= LEVEL_RST;
		end else begin
			rx_level_prev_r <= rx_level;
		end
	end

	// Transmit events fire on the downward crossing only
	assign tx_half_ev = (tx_level_prev_r > TX_HALF_LVL) && (tx_level <= TX_HALF_LVL);
	assign tx_near_ev = (tx_level_prev_r > TX_NEAR_LVL) && (tx_level <= TX_NEAR_LVL);

	// A reserved threshold of 0 never raises the receive event
	assign rx_thresh_ev = (thresh_r >= THRESH_MIN) && (rx_level_prev_r < thresh_r)
		&& (rx_level >= thresh_r);

	// The pin is asynchronous; the first stage feeds only the second
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cts_meta_r <= 1'b0;
			cts_sync_r <= 1'b0;
		end else begin
			cts_meta_r <= i_cts;
			cts_sync_r <= cts_meta_r;
		end
	end

	// Last synchronised level, kept for the change compare
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cts_prev_r <= 1'b0;
		end else begin
			cts_prev_r <= cts_sync_r;
		end
	end

	// Suppress the false change seen while the synchroniser fills after reset
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cts_prime_r <= '0;
		end else begin
			cts_prime_r <= {cts_prime_r[CTS_PRIME_CYC-2:0], 1'b1};
		end
	end

	assign cts_change = cts_prime_r[CTS_PRIME_CYC-1] && (cts_sync_r != cts_prev_r);

	always_comb begin
		ev_set = '0;
		ev_set[EV_TX_HALF] = tx_half_ev;
		ev_set[EV_TX_NEAR] = tx_near_ev;
		ev_set[EV_RX_THRESH] = rx_thresh_ev;
		ev_set[EV_RX_OVERRUN] = rx_overflow;
		ev_set[EV_CTS_CHANGE] = cts_change;
		ev_set[EV_RX_PARITY] = i_rx_parity_err;
		ev_set[EV_RX_FRAME] = i_rx_frame_err;
	end

	assign ev_clr = fl_write ? i_apb.pwdata[EV_W-1:0] : '0;

	// Sticky flags; a new event in the clearing cycle keeps the flag set
	for (genvar g = 0; g < EV_W; g++) begin : g_flag
		always_ff @(posedge i_clk or negedge i_rst_b) begin
			if (!i_rst_b) begin
				flags_r[g] <= EV_FLAGS_RST[g];
			end else if (ev_set[g]) begin
				flags_r[g] <= 1'b1;
			end else if (ev_clr[g]) begin
				flags_r[g] <= 1'b0;
			end
		end
	end

	// Registered so the pin never glitches while flags and enables change together
	assign irq_nxt = |(flags_r & enable_r);

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	assign o_apb = apb_rsp_r;
	assign o_irq = irq_r;
	assign o_rx_threshold = thresh_r;

endmodule

// ### usir_props.sv
// Checker for the status, threshold and interrupt ports of the register block
`timescale 1ns/1ps
module usir_props import usir_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire usir_apb_req_type i_apb,
	input wire usir_apb_rsp_type o_apb,
	input wire logic i_rx_busy,
	input wire logic i_tx_busy,
	input wire logic [LVL_W-1:0] o_rx_threshold,
	input wire logic o_irq
);
	logic acc;
	logic wr;
	logic wr_ctl;
	logic rd_st;
	logic [31:0] d;
	assign d = o_apb.prdata;
	assign acc = i_apb.psel && i_apb.penable && o_apb.pready;
	assign wr = acc && i_apb.pwrite;
	assign wr_ctl = wr && i_apb.paddr == OFF_PORT_CONTROL;
	assign rd_st = acc && !i_apb.pwrite && i_apb.paddr == OFF_PORT_STATUS;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	thr_write_a: assert property (wr_ctl |=> o_rx_threshold == $past(i_apb.pwdata[3:0]))
		else $error("threshold not written");
	thr_hold_a: assert property (!wr_ctl |=> $stable(o_rx_threshold))
		else $error("threshold changed without write");
	tx_level_a: assert property (rd_st |-> d[15:12] <= 4'h8)
		else $error("transmit level above 8");
	rx_level_a: assert property (rd_st |-> d[11:8] <= 4'h8)
		else $error("receive level above 8");
	rx_busy_a: assert property (rd_st |-> d[1] == $past(i_rx_busy, 2))
		else $error("receive busy wrong");
	tx_busy_a: assert property (rd_st |-> d[0] == $past(i_tx_busy, 2))
		else $error("transmit busy wrong");
	empty_full_a: assert property (rd_st |-> d[4] == (d[11:8] == 4'h0) && d[6] == (d[15:12] == 4'h0)
		&& d[5] == (d[11:8] == 4'h8) && d[7] == (d[15:12] == 4'h8)) else $error("full or empty wrong");
	irq_fall_a: assert property ($fell(o_irq) |-> $past(wr) || $past(wr, 2))
		else $error("interrupt fell without write");
endmodule
bind uart_status_irq_regs usir_props u_props (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_apb(i_apb),
	.o_apb(o_apb), .i_rx_busy(i_rx_busy), .i_tx_busy(i_tx_busy),
	.o_rx_threshold(o_rx_threshold), .o_irq(o_irq));

// ### usir_line_model.sv
// Line-side model: queue strobes, error pulses, busy levels and clear-to-send pin
`timescale 1ns/1ps
module usir_line_model (
	input wire logic i_clk,
	output logic [5:0] o_pulse,
	output logic [2:0] o_lvl
);
	initial begin
		o_pulse = 6'h00;
		o_lvl = 3'h0;
	end
	// Bits: tx push, tx pop, rx push, rx pop, parity error, framing error
	task pulse(input logic [5:0] p, input int n);
		repeat (n) begin
			@(posedge i_clk);
			o_pulse <= p;
		end
		@(posedge i_clk);
		o_pulse <= 6'h00;
	endtask
	// Bits: clear-to-send, rx busy, tx busy
	task lv(input logic [2:0] v);
		@(posedge i_clk);
		o_lvl <= v;
	endtask
endmodule

// ### uart_status_irq_regs_test.sv
// Register-level testbench for the serial port status and event block
`timescale 1ns/1ps
module uart_status_irq_regs_test;
	import usir_pkg::*;
	logic i_clk;
	logic i_rst_b;
	usir_apb_req_type req;
	usir_apb_rsp_type rsp;
	logic [5:0] pl;
	logic [2:0] lvl;
	logic [LVL_W-1:0] thr;
	logic irq;
	logic [31:0] q;
	int n_fail;
	int compares;
	uart_status_irq_regs dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_apb(req), .o_apb(rsp),
		.i_tx_push(pl[5]), .i_tx_pop(pl[4]), .i_rx_push(pl[3]), .i_rx_pop(pl[2]),
		.i_tx_busy(lvl[0]), .i_rx_busy(lvl[1]), .i_rx_parity_err(pl[1]),
		.i_rx_frame_err(pl[0]), .i_cts(lvl[2]), .o_rx_threshold(thr), .o_irq(irq));
	usir_line_model line (.i_clk(i_clk), .o_pulse(pl), .o_lvl(lvl));
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	task results();
		$display("compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] v, input logic [31:0] e);
		compares++;
		if (v !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, v);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge i_clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge i_clk);
		req.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge i_clk);
			k++;
		end while (rsp.pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_fail++;
			results();
		end
		q = {rsp.pslverr, rsp.prdata[30:0]};
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input string s);
		apb(1'b0, a, 32'h0);
		chk(s, q, e);
	endtask
	task wt(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	initial begin
		i_rst_b = 1'b0;
		req = '0;
		n_fail = 0;
		compares = 0;
		wt(2);
		i_rst_b <= 1'b1;
		rd(OFF_PORT_CONTROL, 32'h0, "control");
		rd(OFF_PORT_STATUS, 32'h50, "status");
		rd(OFF_EVENT_ENABLE, 32'h0, "enable");
		rd(OFF_EVENT_FLAGS, 32'h0, "flags");
		$display("reset test done");
		apb(1'b1, OFF_PORT_CONTROL, 32'h8);
		rd(OFF_PORT_CONTROL, 32'h8, "control");
		apb(1'b1, OFF_PORT_CONTROL, 32'h1);
		wt(1);
		chk("threshold", thr, 32'h1);
		apb(1'b1, OFF_PORT_STATUS, 32'hFFFF);
		rd(OFF_PORT_STATUS, 32'h50, "status");
		rd(12'h010, 32'h80000000, "unmapped");
		$display("threshold test done");
		line.pulse(6'h20, 9);
		rd(OFF_PORT_STATUS, 32'h8090, "status");
		line.pulse(6'h10, 8);
		rd(OFF_EVENT_FLAGS, 32'h60, "flags");
		apb(1'b1, OFF_EVENT_FLAGS, 32'h0);
		rd(OFF_EVENT_FLAGS, 32'h60, "flags");
		apb(1'b1, OFF_EVENT_FLAGS, 32'h20);
		rd(OFF_EVENT_FLAGS, 32'h40, "flags");
		apb(1'b1, OFF_EVENT_FLAGS, 32'h40);
		rd(OFF_EVENT_FLAGS, 32'h0, "flags");
		$display("transmit queue test done");
		line.pulse(6'h08, 9);
		rd(OFF_PORT_STATUS, 32'h0860, "status");
		rd(OFF_EVENT_FLAGS, 32'h18, "flags");
		line.pulse(6'h03, 1);
		line.lv(3'b100);
		wt(8);
		rd(OFF_EVENT_FLAGS, 32'h1F, "flags");
		$display("receive event test done");
		chk("irq", irq, 32'h0);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, OFF_EVENT_ENABLE, 32'h1 << i);
			wt(3);
			chk("irq", irq, 32'h1);
		end
		apb(1'b1, OFF_EVENT_ENABLE, 32'h0);
		wt(3);
		chk("irq", irq, 32'h0);
		apb(1'b1, OFF_EVENT_ENABLE, 32'hFFFF);
		rd(OFF_EVENT_ENABLE, 32'h7F, "enable");
		apb(1'b1, OFF_EVENT_FLAGS, 32'h7F);
		wt(3);
		chk("irq", irq, 32'h0);
		rd(OFF_EVENT_FLAGS, 32'h0, "flags");
		$display("interrupt test done");
		line.pulse(6'h04, 9);
		line.lv(3'b101);
		rd(OFF_PORT_STATUS, 32'h51, "status");
		line.lv(3'b111);
		rd(OFF_PORT_STATUS, 32'h53, "status");
		$display("busy test done");
		apb(1'b1, OFF_PORT_CONTROL, 32'h0);
		line.pulse(6'h08, 1);
		rd(OFF_EVENT_FLAGS, 32'h0, "flags");
		apb(1'b1, OFF_PORT_CONTROL, 32'h2);
		line.pulse(6'h08, 1);
		rd(OFF_EVENT_FLAGS, 32'h10, "flags");
		chk("irq", irq, 32'h1);
		$display("threshold event test done");
		results();
	end
endmodule
